// ===== flash_sp_pkg.sv
// Shared constants and types for the flash self-programming sequencer
package flash_sp_pkg;
	// ****************************************
	// Register map (byte addresses)
	// ****************************************
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] POINTER_OFS = 8'h04;
	localparam logic [7:0] DATA_OFS = 8'h08;
	localparam logic [7:0] EXTPAGE_OFS = 8'h0C;
	localparam logic [7:0] ISSUE_OFS = 8'h10;
	localparam logic [7:0] INFO_OFS = 8'h14;
	localparam logic [7:0] IRQ_STAT_OFS = 8'h18;
	localparam logic [7:0] IRQ_MASK_OFS = 8'h1C;

	// ****************************************
	// Control register fields
	// ****************************************
	localparam int EN_BIT = 0;
	localparam int BUSY_BIT = 6;
	localparam int CMD_LSB = 0;
	localparam int CMD_W = 5;
	localparam logic [4:0] CMD_LOAD = 5'h01;
	localparam logic [4:0] CMD_ERASE = 5'h03;
	localparam logic [4:0] CMD_WRITE = 5'h05;
	localparam logic [4:0] CMD_LOCK = 5'h09;
	localparam logic [4:0] CMD_REEN = 5'h11;
	localparam logic [4:0] CMD_RST = 5'h00;
	localparam int INFO_FUSE_LSB = 16;

	// ****************************************
	// Interrupt status fields
	// ****************************************
	localparam int IRQ_DONE_BIT = 0;
	localparam int IRQ_DROP_BIT = 1;
	localparam logic [1:0] IRQ_RST = 2'h0;

	// ****************************************
	// Flash geometry
	// ****************************************
	localparam int PAGE_WORDS = 128;
	localparam int WORD_BITS = 7;
	localparam int HALTED_PAGES = 32;
	localparam int BOOT_WORDS_MIN = 512;
	localparam int PAGE_SEL_W = 9;
	localparam int ISSUE_WINDOW = 4;
	localparam logic [15:0] ERASED_WORD = 16'hFFFF;

	// ****************************************
	// Timing
	// ****************************************
	localparam longint unsigned CLK_PERIOD_PS = 5000;
	localparam longint unsigned PROG_MIN_US = 3700;
	localparam longint unsigned PROG_MAX_US = 4500;
	localparam longint unsigned PROG_MIN_CYC = (PROG_MIN_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam longint unsigned PROG_MAX_CYC = (PROG_MAX_US * 1000000) / CLK_PERIOD_PS;

	// ****************************************
	// Types
	// ****************************************
	typedef struct packed {
		logic erase;
		logic write;
		logic lockSet;
		logic [PAGE_SEL_W-1:0] page;
	} flash_req_type;

	typedef enum logic [2:0] {
		IDLE = 3'b001,
		ARMED = 3'b010,
		BUSY = 3'b100
	} seq_state_type;
endpackage : flash_sp_pkg

// ===== prog_timer.sv
// Programming duration counter for flash erase and write operations
`timescale 1ns/1ps
module prog_timer #(
	parameter int unsigned Cycles = 740000
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// Control
	input wire logic start,
	output logic running,
	output logic done
);
	localparam int W = $clog2(Cycles + 1);

	logic [W-1:0] count_r;
	logic done_r;

	always_ff @(posedge sys_clk)
	begin
		if (rst)
			count_r <= '0;
		else if (start)
			count_r <= W'(Cycles);
		else if (count_r != '0)
			count_r <= count_r - 1'b1;
	end

	always_ff @(posedge sys_clk)
	begin
		if (rst)
			done_r <= 1'b0;
		else
			done_r <= (count_r == W'(1));
	end

	assign running = (count_r != '0);
	assign done = done_r;

	start_run_a: assert property (@(posedge sys_clk) disable iff (rst) // [R18]
		start |=> running)
		else $error("timer not running after start");
	run_until_done_a: assert property (@(posedge sys_clk) disable iff (rst) // [R1]
		$fell(running) |-> done && $past(count_r) == W'(1))
		else $error("timer stopped without expiring");
endmodule : prog_timer

// ===== flash_sp_seq.sv
// Flash self-programming sequencer with boot partition and read-region control
`timescale 1ns/1ps
// Function
// (R1) Erase and write last 3.7 to 4.5 ms
// (R2) Two fuse bits select boot size
// (R3) Boot section at top, start is reset vector
// (R4) Top 32 pages form halted-read region
// (R5) Busy flash blocks concurrent-region reads
// (R6) Counter width follows memory size
// (R7) Page holds 128 words, seven low bits
// (R8) Pointer bits shifted one above counter bits
// (R9) Software zeroes word field on page write
// (R10) Pointer bit 0 selects read byte
// (R11) Extended page register supplies bit 16
// (R12) Software polls enable bit before commands
// (R13) Software waits for EEPROM write idle
// (R14) Software masks interrupts around timed write
// (R15) Busy flag held until read-reenable command
// (R16) Command pattern then store within four cycles
// (R17) Page buffer cleared after write, reenable, reset
// (R18) Counter keeps enable set until expiry
module flash_sp_seq
	import flash_sp_pkg::*;
#(
	parameter int CounterBits = 16,
	parameter longint unsigned ProgCycles = flash_sp_pkg::PROG_MIN_CYC
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// APB slave
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Fuse pins and EEPROM status
	input wire logic bootSizeFuseHi,
	input wire logic bootSizeFuseLo,
	input wire logic eepromWriteActive,
	// Fetch check
	input wire logic fetchValid,
	input wire logic [15:0] fetchAddr,
	output logic fetchBlocked,
	// Flash array side
	output flash_sp_pkg::flash_req_type flashReq,
	output logic flashStart,
	output logic [7:0] lockBits,
	input wire logic [6:0] bufRdIdx,
	output logic [15:0] bufRdData,
	// Partition info, byte select and interrupt
	output logic [15:0] bootResetVector,
	output logic [15:0] appSectionEnd,
	output logic byteSelHigh,
	output logic irq
);
	import flash_sp_pkg::*;

	// ****************************************
	// Geometry
	// ****************************************
	localparam logic [16:0] FLASH_WORDS = 17'(1) << CounterBits; // [R6]
	localparam logic [16:0] HALTED_START = FLASH_WORDS - 17'(HALTED_PAGES * PAGE_WORDS); // [R4]
	localparam logic [16:0] PC_MASK = FLASH_WORDS - 17'(1);

	// ****************************************
	// Fuse synchroniser
	// ****************************************
	logic [1:0] fuseMeta_r;
	logic [1:0] fuse_r;

	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			fuseMeta_r <= 2'h3;
			fuse_r <= 2'h3;
		end
		else
		begin
			fuseMeta_r <= {bootSizeFuseHi, bootSizeFuseLo};
			fuse_r <= fuseMeta_r;
		end
	end

	// ****************************************
	// Partition boundaries
	// ****************************************
	logic [16:0] bootWords;
	logic [16:0] bootStart;

	assign bootWords = 17'(BOOT_WORDS_MIN) << ~fuse_r; // [R2]
	assign bootStart = FLASH_WORDS - bootWords; // [R3]

	logic [15:0] bootResetVector_r;
	logic [15:0] appSectionEnd_r;

	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			bootResetVector_r <= '0;
			appSectionEnd_r <= '0;
		end
		else
		begin
			bootResetVector_r <= bootStart[15:0]; // [R3]
			appSectionEnd_r <= 16'(bootStart - 17'(1));
		end
	end

	assign bootResetVector = bootResetVector_r;
	assign appSectionEnd = appSectionEnd_r;

	// ****************************************
	// APB decode
	// ****************************************
	logic wrAcc;
	logic rdSetup;
	logic mapped;

	assign wrAcc = psel && penable && pwrite;
	assign rdSetup = psel && !penable && !pwrite;
	assign mapped = (paddr == CTRL_OFS) || (paddr == POINTER_OFS) || (paddr == DATA_OFS)
		|| (paddr == EXTPAGE_OFS) || (paddr == ISSUE_OFS) || (paddr == INFO_OFS)
		|| (paddr == IRQ_STAT_OFS) || (paddr == IRQ_MASK_OFS);
	assign pready = 1'b1;
	assign pslverr = psel && penable && !mapped;

	// ****************************************
	// Software registers
	// ****************************************
	seq_state_type state_r;
	logic [4:0] cmd_r;
	logic [15:0] pointer_r;
	logic [15:0] data_r;
	logic [7:0] extPage_r;
	logic [1:0] irqMask_r;
	logic busyFlag_r;

	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			pointer_r <= '0;
			data_r <= '0;
			extPage_r <= '0;
			irqMask_r <= IRQ_RST;
		end
		else if (wrAcc)
		begin
			if (paddr == POINTER_OFS)
				pointer_r <= pwdata[15:0];
			if (paddr == DATA_OFS)
				data_r <= pwdata[15:0];
			if (paddr == EXTPAGE_OFS)
				extPage_r <= pwdata[7:0];
			if (paddr == IRQ_MASK_OFS)
				irqMask_r <= pwdata[1:0];
		end
	end

	// ****************************************
	// Address mapping
	// ****************************************
	logic [16:0] pcAddr;
	logic [6:0] wordIdx;
	logic [PAGE_SEL_W-1:0] pageSel;

	// Bit 15 of the counter comes from the extended page register
	assign pcAddr = {extPage_r[0], pointer_r} >> 1 & PC_MASK; // [R8] [R11]
	assign wordIdx = pointer_r[WORD_BITS:1]; // [R7] [R8]
	// Word field is ignored here, only the page select counts
	assign pageSel = PAGE_SEL_W'(pcAddr >> WORD_BITS); // [R7] [R9]

	// ****************************************
	// Command sequencing
	// ****************************************
	logic ctrlWr;
	logic ctrlOk;
	logic issueWr;
	logic exec;
	logic [2:0] window_r;
	logic timerStart;
	logic timerDone;
	logic timerRunning;
	seq_state_type state_nxt;

	assign ctrlWr = wrAcc && (paddr == CTRL_OFS);
	// A pending EEPROM write refuses the command
	assign ctrlOk = ctrlWr && (state_r == IDLE) && !eepromWriteActive && pwdata[EN_BIT]; // [R13] [R12]
	assign issueWr = wrAcc && (paddr == ISSUE_OFS);
	assign exec = issueWr && (state_r == ARMED); // [R16]
	assign timerStart = exec && ((cmd_r == CMD_ERASE) || (cmd_r == CMD_WRITE) || (cmd_r == CMD_LOCK));

	always_comb
	begin
		state_nxt = state_r;
		unique case (state_r)
			IDLE:
				if (ctrlOk)
					state_nxt = ARMED;
			ARMED:
				if (timerStart)
					state_nxt = BUSY;
				else if (exec || window_r == 3'(1))
					state_nxt = IDLE; // [R16]
			BUSY:
				if (timerDone)
					state_nxt = IDLE; // [R18]
			default:
				state_nxt = IDLE;
		endcase
	end

	always_ff @(posedge sys_clk)
	begin
		if (rst)
			state_r <= IDLE;
		else
			state_r <= state_nxt;
	end

	always_ff @(posedge sys_clk)
	begin
		if (rst)
			window_r <= '0;
		else if (ctrlOk)
			window_r <= 3'(ISSUE_WINDOW);
		else if (window_r != '0)
			window_r <= window_r - 1'b1;
	end

	always_ff @(posedge sys_clk)
	begin
		if (rst)
			cmd_r <= CMD_RST;
		else if (ctrlOk)
			cmd_r <= pwdata[CMD_LSB +: CMD_W];
	end

	prog_timer #(
		.Cycles(32'(ProgCycles))
	) progTimer (
		.sys_clk(sys_clk),
		.rst(rst),
		.start(timerStart), // [R1]
		.running(timerRunning),
		.done(timerDone)
	);

	// ****************************************
	// Concurrent-read busy flag
	// ****************************************
	logic reenExec;

	assign reenExec = exec && (cmd_r == CMD_REEN);

	always_ff @(posedge sys_clk)
	begin
		if (rst)
			busyFlag_r <= 1'b0;
		else if (exec && ((cmd_r == CMD_ERASE) || (cmd_r == CMD_WRITE)))
			busyFlag_r <= 1'b1;
		else if (reenExec)
			busyFlag_r <= 1'b0; // [R15]
	end

	// Reads below the halted region fail while the busy flag is set, from erase or write until reenable
	assign fetchBlocked = fetchValid && busyFlag_r && ((17'(fetchAddr) & PC_MASK) < HALTED_START); // [R5] [R4]

	// ****************************************
	// Flash request
	// ****************************************
	flash_req_type flashReq_r;
	logic flashStart_r;
	logic [7:0] lockBits_r;

	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			flashReq_r <= '0;
			flashStart_r <= 1'b0;
			lockBits_r <= 8'hFF;
		end
		else
		begin
			flashStart_r <= timerStart;
			if (timerStart)
			begin
				flashReq_r.erase <= (cmd_r == CMD_ERASE);
				flashReq_r.write <= (cmd_r == CMD_WRITE);
				flashReq_r.lockSet <= (cmd_r == CMD_LOCK);
				flashReq_r.page <= pageSel; // [R9]
			end
			if (timerStart && cmd_r == CMD_LOCK)
				lockBits_r <= data_r[7:0];
		end
	end

	assign flashReq = flashReq_r;
	assign flashStart = flashStart_r;
	assign lockBits = lockBits_r;

	// ****************************************
	// Temporary page buffer
	// ****************************************
	logic [15:0] pageBuf [PAGE_WORDS];
	logic [PAGE_WORDS-1:0] bufValid_r;
	logic [15:0] bufRdData_r;
	logic loadExec;
	logic bufClear;

	assign loadExec = exec && (cmd_r == CMD_LOAD);
	assign bufClear = reenExec || (timerDone && flashReq_r.write); // [R17]

	// Each word may be loaded once until the buffer is cleared
	always_ff @(posedge sys_clk)
	begin
		if (loadExec && !bufValid_r[wordIdx])
			pageBuf[wordIdx] <= data_r;
	end

	always_ff @(posedge sys_clk)
	begin
		if (rst || bufClear)
			bufValid_r <= '0; // [R17]
		else if (loadExec)
			bufValid_r[wordIdx] <= 1'b1;
	end

	always_ff @(posedge sys_clk)
	begin
		if (rst)
			bufRdData_r <= ERASED_WORD;
		else
			bufRdData_r <= bufValid_r[bufRdIdx] ? pageBuf[bufRdIdx] : ERASED_WORD;
	end

	assign bufRdData = bufRdData_r;

	// ****************************************
	// Byte select for program-memory loads
	// ****************************************
	logic byteSelHigh_r;

	always_ff @(posedge sys_clk)
	begin
		if (rst)
			byteSelHigh_r <= 1'b0;
		else
			byteSelHigh_r <= pointer_r[0]; // [R10]
	end

	assign byteSelHigh = byteSelHigh_r;

	// ****************************************
	// Interrupts
	// ****************************************
	logic [1:0] irqStat_r;
	logic [1:0] irqSet;
	logic [1:0] irqClr;

	assign irqSet[IRQ_DONE_BIT] = (state_r != IDLE) && (state_nxt == IDLE) && exec | timerDone;
	assign irqSet[IRQ_DROP_BIT] = (ctrlWr && !ctrlOk) || (state_r == ARMED && !issueWr && window_r == 3'(1));
	assign irqClr = (wrAcc && paddr == IRQ_STAT_OFS) ? pwdata[1:0] : 2'h0;

	// A new event wins over a clear in the same cycle
	always_ff @(posedge sys_clk)
	begin
		if (rst)
			irqStat_r <= IRQ_RST;
		else
			irqStat_r <= (irqStat_r & ~irqClr) | irqSet;
	end

	assign irq = |(irqStat_r & irqMask_r);

	// ****************************************
	// Read data
	// ****************************************
	logic [7:0] ctrlView;

	assign ctrlView = {1'b0, busyFlag_r, 1'b0, cmd_r[4:1], state_r != IDLE}; // [R18] [R15]

	always_ff @(posedge sys_clk)
	begin
		if (rst)
			prdata <= '0;
		else if (rdSetup)
		begin
			unique case (paddr)
				CTRL_OFS: prdata <= {24'h000000, ctrlView};
				POINTER_OFS: prdata <= {16'h0000, pointer_r};
				DATA_OFS: prdata <= {16'h0000, data_r};
				EXTPAGE_OFS: prdata <= {24'h000000, extPage_r};
				INFO_OFS: prdata <= {14'h0, fuse_r, bootResetVector_r};
				IRQ_STAT_OFS: prdata <= {30'h0, irqStat_r};
				IRQ_MASK_OFS: prdata <= {30'h0, irqMask_r};
				default: prdata <= '0;
			endcase
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	win_expire_a: assert property (@(posedge sys_clk) disable iff (rst) // [R16]
		ctrlOk ##1 (!issueWr) [*4] |=> state_r == IDLE)
		else $error("command window did not close after four cycles");
	busy_hold_a: assert property (@(posedge sys_clk) disable iff (rst) // [R15]
		busyFlag_r && !reenExec |=> busyFlag_r)
		else $error("busy flag dropped without reenable");
	fetch_block_a: assert property (@(posedge sys_clk) disable iff (rst) // [R5]
		busyFlag_r && fetchValid && fetchAddr[15:12] != 4'hF && CounterBits == 16 |-> fetchBlocked)
		else $error("concurrent region readable while busy");
	halted_free_a: assert property (@(posedge sys_clk) disable iff (rst) // [R4]
		CounterBits == 16 && fetchAddr >= 16'hF000 |-> !fetchBlocked)
		else $error("halted region blocked");
	boot_vec_a: assert property (@(posedge sys_clk) disable iff (rst) // [R2]
		CounterBits == 16 && fuse_r == 2'b00 |=> bootResetVector_r == 16'hF000 && appSectionEnd_r == 16'hEFFF)
		else $error("boot start wrong for fuse 00");
	done_clear_a: assert property (@(posedge sys_clk) disable iff (rst) // [R18]
		state_r == BUSY && timerDone |=> state_r == IDLE && irqStat_r[IRQ_DONE_BIT] && !ctrlView[EN_BIT])
		else $error("enable bit not cleared at expiry");
	buf_clear_a: assert property (@(posedge sys_clk) disable iff (rst) // [R17]
		timerDone && flashReq_r.write |=> bufValid_r == '0)
		else $error("page buffer not cleared after write");
	page_sel_a: assert property (@(posedge sys_clk) disable iff (rst) // [R8]
		timerStart |=> flashStart && flashReq_r.page == PAGE_SEL_W'({$past(extPage_r[0]), $past(pointer_r)} >> 8))
		else $error("page select not taken from pointer bits");
	eeprom_block_a: assert property (@(posedge sys_clk) disable iff (rst) // [R13]
		state_r == IDLE && eepromWriteActive |=> state_r == IDLE)
		else $error("command accepted during EEPROM write");
	byte_sel_a: assert property (@(posedge sys_clk) disable iff (rst) // [R10]
		##1 byteSelHigh == $past(pointer_r[0]))
		else $error("byte select not from pointer bit 0");
endmodule : flash_sp_seq

// ===== tb_top.sv
// Self-checking testbench for the flash self-programming sequencer
`timescale 1ns/1ps
module tb_top;
	import flash_sp_pkg::*;
	// Short programming time keeps the run brief
	localparam int Prog = 40;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] paddr = 8'h00;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic fuseHi = 1'b1;
	logic fuseLo = 1'b1;
	logic eeActive = 1'b0;
	logic fetchValid = 1'b0;
	logic [15:0] fetchAddr = 16'h0000;
	logic fetchBlocked;
	flash_req_type flashReq;
	logic flashStart;
	logic [7:0] lockBits;
	logic [6:0] bufRdIdx = 7'h00;
	logic [15:0] bufRdData;
	logic [15:0] bootResetVector;
	logic [15:0] appSectionEnd;
	logic byteSelHigh;
	logic irq;
	int err_total = 0;
	int tests_run = 0;
	int cycles = 0;
	int startCount = 0;
	int n;
	int t0;
	logic [31:0] rd;
	logic se;
	logic [15:0] vec;

	flash_sp_seq #(.CounterBits(16), .ProgCycles(Prog)) dut (.sys_clk(sys_clk), .rst(rst), .paddr(paddr),
		.psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .bootSizeFuseHi(fuseHi), .bootSizeFuseLo(fuseLo), .eepromWriteActive(eeActive),
		.fetchValid(fetchValid), .fetchAddr(fetchAddr), .fetchBlocked(fetchBlocked), .flashReq(flashReq),
		.flashStart(flashStart), .lockBits(lockBits), .bufRdIdx(bufRdIdx), .bufRdData(bufRdData),
		.bootResetVector(bootResetVector), .appSectionEnd(appSectionEnd), .byteSelHigh(byteSelHigh), .irq(irq));

	always #2.5 sys_clk = ~sys_clk;

	// ****************************************
	// Monitors and hang guard
	// ****************************************
	always @(posedge sys_clk)
	begin
		cycles++;
		if (flashStart === 1'b1)
			startCount++;
		if (cycles == 20000)
		begin
			err_total++;
			$display("ERROR t=%0t timeout", $time);
			complete_run();
		end
	end

	// ****************************************
	// Tasks
	// ****************************************
	task automatic complete_run();
		$display("Checks %0d, errors %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : complete_run

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			err_total++;
			$display("ERROR t=%0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// Request is held until pready is seen high at a rising edge
	task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
		int k;
		@(posedge sys_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		k = 0;
		do
		begin
			@(posedge sys_clk);
			k++;
		end
		while (pready !== 1'b1 && k < 50);
		if (pready !== 1'b1)
		begin
			err_total++;
			$display("ERROR t=%0t no ready from slave", $time);
		end
		rd = prdata;
		se = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : xfer

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		xfer(a, 1'b1, d);
	endtask : wr

	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
		xfer(a, 1'b0, 32'h0000_0000);
		chk(rd, exp);
	endtask : rdchk

	task automatic issue(input logic [4:0] c);
		wr(CTRL_OFS, {27'h0, c});
		// Pair goes out with one idle cycle between, nothing may slip in between
		wr(ISSUE_OFS, 32'h0000_0000);
	endtask : issue

	task automatic wait_idle();
		int k;
		k = 0;
		do
		begin
			xfer(CTRL_OFS, 1'b0, 32'h0000_0000);
			k++;
		end
		while (rd[EN_BIT] !== 1'b0 && k < 100);
		if (rd[EN_BIT] !== 1'b0)
		begin
			err_total++;
			$display("ERROR t=%0t enable bit stuck", $time);
		end
	endtask : wait_idle

	task automatic sample_buf(input logic [6:0] idx, input logic [15:0] exp);
		bufRdIdx <= idx;
		repeat (2) @(posedge sys_clk);
		chk({16'h0, bufRdData}, {16'h0, exp});
	endtask : sample_buf

	// ****************************************
	// Main sequence
	// ****************************************
	initial
	begin
		repeat (8) @(posedge sys_clk);
		rst <= 1'b0;
		// Every fuse pattern, 00 first and once more last
		for (int f = 0; f < 5; f++)
		begin
			{fuseHi, fuseLo} <= 2'(f);
			repeat (6) @(posedge sys_clk);
			vec = 16'(17'h10000 - (17'd512 << (3 - (f % 4))));
			chk({16'h0, bootResetVector}, {16'h0, vec});
			chk({16'h0, appSectionEnd}, {16'h0, vec - 16'h0001});
			rdchk(INFO_OFS, {14'h0, 2'(f), vec});
		end
		xfer(8'h20, 1'b0, 32'h0000_0000);
		chk({31'h0, se}, 32'h1);
		chk(rd, 32'h0);
		wr(IRQ_MASK_OFS, 32'h1);
		// Erase of the first halted-region page (0x1E0) through the extended page bit
		wr(EXTPAGE_OFS, 32'h1);
		wr(POINTER_OFS, 32'hE000);
		n = startCount;
		issue(CMD_ERASE);
		while (startCount == n && cycles < 19000)
			@(posedge sys_clk);
		t0 = cycles;
		chk(32'(flashReq), {20'h0, 3'b100, 9'h1E0});
		fetchValid <= 1'b1;
		fetchAddr <= 16'h1000;
		@(posedge sys_clk);
		chk({31'h0, fetchBlocked}, 32'h1);
		fetchAddr <= 16'hF000;
		@(posedge sys_clk);
		chk({31'h0, fetchBlocked}, 32'h0);
		fetchAddr <= 16'hEFFF;
		@(posedge sys_clk);
		chk({31'h0, fetchBlocked}, 32'h1);
		// A command while busy is refused
		wr(CTRL_OFS, {27'h0, CMD_LOAD});
		while (irq !== 1'b1 && cycles < t0 + 200)
			@(posedge sys_clk);
		chk(32'((cycles - t0 >= Prog - 1) && (cycles - t0 <= Prog + 3)), 32'h1);
		rdchk(IRQ_STAT_OFS, 32'h3);
		xfer(CTRL_OFS, 1'b0, 32'h0);
		chk({31'h0, rd[BUSY_BIT]}, 32'h1);
		chk({31'h0, rd[EN_BIT]}, 32'h0);
		chk({31'h0, fetchBlocked}, 32'h1);
		wr(IRQ_STAT_OFS, 32'h3);
		// Clear lands at the access edge, look one edge later
		@(posedge sys_clk);
		chk({31'h0, irq}, 32'h0);
		issue(CMD_REEN);
		wait_idle();
		chk({31'h0, rd[BUSY_BIT]}, 32'h0);
		chk({31'h0, fetchBlocked}, 32'h0);
		fetchValid <= 1'b0;
		// Buffer load, then page write clears it
		wr(EXTPAGE_OFS, 32'h0);
		wr(POINTER_OFS, 32'h000A);
		wr(DATA_OFS, 32'h1234);
		issue(CMD_LOAD);
		wait_idle();
		sample_buf(7'h05, 16'h1234);
		sample_buf(7'h06, ERASED_WORD);
		wr(POINTER_OFS, 32'h0100);
		issue(CMD_WRITE);
		wait_idle();
		chk(32'(flashReq), {20'h0, 3'b010, 9'h001});
		sample_buf(7'h05, ERASED_WORD);
		issue(CMD_REEN);
		wait_idle();
		// Lock bits from the data register
		wr(DATA_OFS, 32'h00C3);
		issue(CMD_LOCK);
		wait_idle();
		chk({24'h0, lockBits}, 32'hC3);
		chk({31'h0, flashReq.lockSet}, 32'h1);
		wr(POINTER_OFS, 32'h0001);
		repeat (2) @(posedge sys_clk);
		chk({31'h0, byteSelHigh}, 32'h1);
		// Pending EEPROM write blocks the control register
		wr(IRQ_STAT_OFS, 32'h3);
		eeActive <= 1'b1;
		wr(CTRL_OFS, {27'h0, CMD_LOAD});
		eeActive <= 1'b0;
		rdchk(IRQ_STAT_OFS, 32'h2);
		// Store arriving after the four-cycle window
		wr(IRQ_STAT_OFS, 32'h3);
		n = startCount;
		wr(CTRL_OFS, {27'h0, CMD_ERASE});
		repeat (6) @(posedge sys_clk);
		wr(ISSUE_OFS, 32'h0);
		repeat (4) @(posedge sys_clk);
		chk(32'(startCount - n), 32'h0);
		rdchk(IRQ_STAT_OFS, 32'h2);
		// Reset empties the page buffer
		wr(POINTER_OFS, 32'h0004);
		issue(CMD_LOAD);
		wait_idle();
		sample_buf(7'h02, 16'h00C3);
		// A second load of the same word keeps the first
		wr(DATA_OFS, 32'h5555);
		issue(CMD_LOAD);
		wait_idle();
		sample_buf(7'h02, 16'h00C3);
		rst <= 1'b1;
		@(posedge sys_clk);
		rst <= 1'b0;
		repeat (4) @(posedge sys_clk);
		sample_buf(7'h02, ERASED_WORD);
		rdchk(IRQ_STAT_OFS, 32'h0);
		complete_run();
	end
endmodule : tb_top
